// [rtl/rdc_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz aclk and 32-bit axi4-lite word addressing
// Contract
// - low reset pulse restores every register default
// - master reset empties fifos, clears sync
// - master reset tri-states drivers, stops sampling
// - soft reset bit flushes, other registers kept
// - soft reset holds until host writes zero
// - drivers high impedance during reset, in loopback
// - receivers disconnected during reset and loopback
// - digital encoder outputs always driven, loop data
// - converter disable turns internal drivers off
// - overflow flag clears on sync loss, reset
`ifndef RDC_REGS_SVH
`define RDC_REGS_SVH
`define RDC_OFS_CTRL_B      4'h0
`define RDC_OFS_STATUS      4'h4
`define RDC_BIT_LOOPBACK    0
`define RDC_BIT_SOFT_RESET  3
`define RDC_CTRL_B_RESET    8'h00
`define RDC_MR_MIN_NS       100
`define RDC_CLK_NS          50
`define RDC_MR_MIN_CYC      ((`RDC_MR_MIN_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`endif

// [rtl/rdc_pkg.sv]
// types shared by the reset and driver enable control
// assumes nothing beyond the constants header
package rdc_pkg;
    // four encoder lines travel together
    typedef struct packed {
        logic biphase_a;
        logic biphase_b;
        logic bipolar_a;
        logic bipolar_b;
    } rdc_enc_t;
    typedef enum logic [2:0] {
        RDC_ST_HARD = 3'b001,
        RDC_ST_SOFT = 3'b010,
        RDC_ST_RUN  = 3'b100
    } rdc_state_t;
endpackage

// [rtl/rdc_sync.sv]
// two-flop synchroniser for pins from outside the aclk domain
// assumes the pin is a slow level
module rdc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      sync_q
);
    logic meta_q;
    // first stage feeds only the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end
endmodule

// [rtl/rdc_ctrl.sv]
// reset, loopback and driver enable control with axi4-lite registers
// assumes aclk at 20 MHz; master_reset_n and pins are asynchronous
`include "rdc_regs.svh"
module rdc_ctrl #(
    parameter int MR_MIN_CYC = `RDC_MR_MIN_CYC
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             master_reset_n,
    input  wire logic             converter_disable,
    input  wire logic             in_sync_indication,
    input  wire logic             rx_overflow_event,
    input  wire rdc_pkg::rdc_enc_t encoder_in,
    input  wire logic [3:0]       awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [3:0]       araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    output logic                  block_reset_n,
    output logic                  line_drive_en,
    output logic                  rx_sample_en,
    output logic                  loopback_sel,
    output rdc_pkg::rdc_enc_t     encoder_out,
    output logic                  rx_overflow_flag,
    output logic                  rx_overflow_pin
);
    // a zero minimum would let any glitch reset the block
    if (MR_MIN_CYC < 1)
        $error("MR_MIN_CYC must be at least 1");

    // the low sample that completes a minimum-length pulse
    localparam int MR_LAST = MR_MIN_CYC - 1;

    logic mr_n_s;
    logic conv_off_s;
    logic [7:0] ctrl_b_q;
    logic [$clog2(MR_MIN_CYC+1)-1:0] mr_cnt_q;
    logic hard_q;
    rdc_pkg::rdc_state_t state_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_strb0_q;
    logic ovf_q;

    // master reset pin crosses before use; idles in reset
    rdc_sync #(.RST_VAL(1'b0)) u_mr_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (master_reset_n),
        .sync_q  (mr_n_s)
    );
    rdc_sync #(.RST_VAL(1'b0)) u_conv_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (converter_disable),
        .sync_q  (conv_off_s)
    );

    // a low pulse shorter than the minimum is ignored as a glitch
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mr_cnt_q <= '0;
            hard_q   <= 1'b1;
        end
        else if (!mr_n_s)
        begin
            if (mr_cnt_q != MR_LAST[$bits(mr_cnt_q)-1:0])
                mr_cnt_q <= mr_cnt_q + 1'b1;
            else
                hard_q <= 1'b1;
        end
        else
        begin
            mr_cnt_q <= '0;
            hard_q   <= 1'b0; // release on one edge
        end
    end

    function automatic logic is_ctrl(input logic [3:0] a);
        is_ctrl = (a == `RDC_OFS_CTRL_B);
    endfunction

    // write channel: address and data taken in either order
    wire wr_go = aw_hold_q && w_hold_q && !bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb0_q <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= 2'h0;
        end
        else
        begin
            awready <= !aw_hold_q && !awready && awvalid;
            wready  <= !w_hold_q && !wready && wvalid;
            if (awvalid && awready)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold_q  <= 1'b1;
                w_data_q  <= wdata;
                w_strb0_q <= wstrb[0];
            end
            if (wr_go)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (is_ctrl(aw_addr_q) ||
                              aw_addr_q == `RDC_OFS_STATUS) ? 2'h0 : 2'h2;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // control register survives soft reset, cleared by hard reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn || hard_q)
            ctrl_b_q <= `RDC_CTRL_B_RESET;
        else if (wr_go && is_ctrl(aw_addr_q) && w_strb0_q)
            ctrl_b_q <= w_data_q[7:0];
    end

    // reset state machine; soft state held while the bit stays 1
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= rdc_pkg::RDC_ST_HARD;
        else if (hard_q)
            state_q <= rdc_pkg::RDC_ST_HARD;
        else if (ctrl_b_q[`RDC_BIT_SOFT_RESET])
            state_q <= rdc_pkg::RDC_ST_SOFT;
        else
            state_q <= rdc_pkg::RDC_ST_RUN;
    end

    // enables; a one-cycle lag keeps all outputs registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            block_reset_n <= 1'b0;
            line_drive_en <= 1'b0;
            rx_sample_en  <= 1'b0;
            loopback_sel  <= 1'b0;
        end
        else
        begin
            block_reset_n <= (state_q == rdc_pkg::RDC_ST_RUN);
            line_drive_en <= (state_q == rdc_pkg::RDC_ST_RUN) &&
                             !ctrl_b_q[`RDC_BIT_LOOPBACK] &&
                             !conv_off_s;
            rx_sample_en  <= (state_q == rdc_pkg::RDC_ST_RUN) &&
                             !ctrl_b_q[`RDC_BIT_LOOPBACK];
            loopback_sel  <= ctrl_b_q[`RDC_BIT_LOOPBACK];
        end
    end

    // encoder lines always driven, also the loopback sampler source
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            encoder_out <= '0;
        else
            encoder_out <= encoder_in;
    end

    // overflow: set wins over sync loss but not over reset, cleared by sync loss or reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_q != rdc_pkg::RDC_ST_RUN)
            ovf_q <= 1'b0;
        else if (rx_overflow_event)
            ovf_q <= 1'b1;
        else if (!in_sync_indication)
            ovf_q <= 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_overflow_flag <= 1'b0;
            rx_overflow_pin  <= 1'b0;
        end
        else
        begin
            rx_overflow_flag <= ovf_q;
            rx_overflow_pin  <= ovf_q;
        end
    end

    // read channel: one read at a time, unmapped gives slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= 2'h0;
        end
        else
        begin
            arready <= !arready && !rvalid && arvalid;
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rresp  <= 2'h0;
                if (is_ctrl(araddr))
                    rdata <= {24'h000000, ctrl_b_q};
                else if (araddr == `RDC_OFS_STATUS)
                    rdata <= {26'h0, ovf_q, conv_off_s,
                              rx_sample_en, line_drive_en,
                              state_q == rdc_pkg::RDC_ST_SOFT,
                              state_q == rdc_pkg::RDC_ST_HARD};
                else
                begin
                    rdata <= '0;
                    rresp <= 2'h2;
                end
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end
endmodule

// [dv/rdc_ctrl_monitor.sv]
// checker of driver enable, loopback, encoder and overflow relations
// assumes one aclk domain; bound onto rdc_ctrl
module rdc_ctrl_monitor (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              converter_disable,
    input wire logic              in_sync_indication,
    input wire logic              rx_overflow_event,
    input wire rdc_pkg::rdc_enc_t encoder_in,
    input wire logic              block_reset_n,
    input wire logic              line_drive_en,
    input wire logic              rx_sample_en,
    input wire logic              loopback_sel,
    input wire rdc_pkg::rdc_enc_t encoder_out,
    input wire logic              rx_overflow_flag,
    input wire logic              rx_overflow_pin
);
    // pins pass a synchroniser, so levels get a few edges of slack
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    loop_drv_off_a:
        assert property (loopback_sel[*3] |-> !line_drive_en)
        else $error("line drivers on in loopback");
    loop_rx_off_a:
        assert property (loopback_sel[*3] |-> !rx_sample_en)
        else $error("receivers sampled in loopback");
    conv_drv_off_a:
        assert property (converter_disable[*6] |-> !line_drive_en)
        else $error("line drivers on with converter off");
    enc_follow_a:
        assert property ($past(aresetn) |-> encoder_out == $past(encoder_in))
        else $error("encoder outputs not following");
    ovf_pin_eq_a:
        assert property (rx_overflow_flag == rx_overflow_pin)
        else $error("overflow flag and pin differ");
    ovf_set_a:
        assert property (rx_overflow_event ##1 block_reset_n
                         |=> rx_overflow_flag)
        else $error("overflow not set");
    ovf_clr_a:
        assert property (!in_sync_indication && !rx_overflow_event
                         |=> ##1 !rx_overflow_flag)
        else $error("overflow not cleared on sync loss");
    rst_all_off_a:
        assert property (!block_reset_n[*2] |-> !line_drive_en && !rx_sample_en)
        else $error("enables on during reset");
    rel_one_edge_a:
        assert property ($rose(block_reset_n) |-> rx_sample_en || loopback_sel)
        else $error("reset release not on one edge");
    cover property (loopback_sel[*3]);
    cover property ($fell(block_reset_n));
    cover property ($rose(rx_overflow_flag));
endmodule

bind rdc_ctrl rdc_ctrl_monitor u_mon (.aclk, .aresetn, .converter_disable,
    .in_sync_indication, .rx_overflow_event, .encoder_in, .block_reset_n,
    .line_drive_en, .rx_sample_en, .loopback_sel, .encoder_out,
    .rx_overflow_flag, .rx_overflow_pin);

// [dv/rdc_enc_src.sv]
// far-side encoder data source, new pattern on every clock
// assumes it shares aclk with the block
module rdc_enc_src (
    input  wire logic        aclk,
    output rdc_pkg::rdc_enc_t enc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q = 4'h0;
    // odd step so every bit toggles often; a stuck bit shows quickly
    always @(posedge aclk)
    begin
        cnt_q <= cnt_q + 4'h3;
    end
    assign enc = rdc_pkg::rdc_enc_t'(cnt_q);
endmodule

// [dv/reset_and_driver_enable_ctrl_tb.sv]
// self-checking bench for rdc_ctrl over axi4-lite
// assumes 50 ns aclk; pins driven in step with aclk
module reset_and_driver_enable_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, master_reset_n = 1'h1;
    logic converter_disable = 1'h0, in_sync_indication = 1'h1;
    logic rx_overflow_event = 1'h0, enc_ok = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid;
    logic arready, rvalid, block_reset_n, line_drive_en, rx_sample_en;
    logic loopback_sel, rx_overflow_flag, rx_overflow_pin;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic [1:0]  bresp, rresp, resp_q;
    rdc_pkg::rdc_enc_t encoder_in, encoder_out, enc_prev;
    int num_errors = 0, n_checks = 0, cycles = 0, seed = 21439, ctrl_m = 0;
    always #25 aclk = ~aclk;
    rdc_ctrl #(.MR_MIN_CYC(2)) uut (.aclk, .aresetn, .master_reset_n,
        .converter_disable, .in_sync_indication, .rx_overflow_event,
        .encoder_in, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .block_reset_n,
        .line_drive_en, .rx_sample_en, .loopback_sel, .encoder_out,
        .rx_overflow_flag, .rx_overflow_pin);
    rdc_enc_src u_src (.aclk, .enc(encoder_in));
    task chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    // model of the four enables from ctrl bits, pins and hard reset
    task chk_p(input bit hard);
        bit r;
        bit l;
        r = hard | ctrl_m[3];
        l = ctrl_m[0];
        chk_w("enables", {~r, ~r & ~l & ~converter_disable, ~r & ~l, l},
              {block_reset_n, line_drive_en, rx_sample_en, loopback_sel});
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // both channels offered together, each dropped when taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp_q = bresp;
        bready <= 1'h0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'h0;
    endtask
    task ovf_pulse;
        @(posedge aclk);
        rx_overflow_event <= 1'h1;
        @(posedge aclk);
        rx_overflow_event <= 1'h0;
        cyc(2);
        chk_w("rx_overflow_pin", 1, rx_overflow_pin);
    endtask
    // timeout and encoder delay model, every edge
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            print_verdict;
        end
        if (enc_ok) chk_w("encoder_out", enc_prev, encoder_out);
        enc_prev <= encoder_in;
        enc_ok <= aresetn;
    end
    initial
    begin
        cyc(6);
        aresetn <= 1'h1;
        cyc(8);
        chk_p(0);
        rd(4'h0);
        chk_w("ctrl_b", 0, rd_q);
        rd(4'h4);
        chk_w("status", 32'h0C, rd_q);
        $display("test defaults done");
        ovf_pulse;
        ctrl_m = ($random(seed) & 32'hF0) | 32'h08;
        wr(4'h0, ctrl_m);
        cyc(3);
        chk_p(0);
        chk_w("rx_overflow_flag", 0, rx_overflow_flag);
        cyc(20);
        chk_p(0);
        rd(4'h0);
        chk_w("ctrl_b", ctrl_m, rd_q);
        ctrl_m = (ctrl_m & 32'hF0) | 32'h01;
        wr(4'h0, ctrl_m);
        cyc(3);
        chk_p(0);
        cyc(20);
        chk_p(0);
        $display("test soft reset and loopback done");
        ctrl_m = ctrl_m & 32'hF0;
        wr(4'h0, ctrl_m);
        converter_disable <= 1'h1;
        cyc(6);
        chk_p(0);
        converter_disable <= 1'h0;
        cyc(6);
        chk_p(0);
        ovf_pulse;
        in_sync_indication <= 1'h0;
        cyc(3);
        chk_w("rx_overflow_flag", 0, rx_overflow_flag);
        in_sync_indication <= 1'h1;
        $display("test converter and overflow done");
        wr(4'h0, ($random(seed) & 32'hF0) | 32'h01);
        master_reset_n <= 1'h0;
        ctrl_m = 0;
        cyc(8);
        chk_p(1);
        master_reset_n <= 1'h1;
        cyc(8);
        chk_p(0);
        rd(4'h0);
        chk_w("ctrl_b", 0, rd_q);
        wr(4'h8, $random(seed));
        chk_w("bresp", 2, resp_q);
        rd(4'hC);
        chk_w("rresp", 2, resp_q);
        wr(4'h4, 32'hFF);
        rd(4'h0);
        chk_w("ctrl_b", 0, rd_q);
        // shortest legal pulse, two cycles of 50 ns, must still reset
        wr(4'h0, ($random(seed) & 32'hF0) | 32'h10);
        master_reset_n <= 1'h0;
        cyc(2);
        master_reset_n <= 1'h1;
        cyc(8);
        rd(4'h0);
        chk_w("ctrl_b", 0, rd_q);
        // a write without the low byte strobe leaves the byte alone
        wstrb <= 4'h0;
        wr(4'h0, 32'h11);
        wstrb <= 4'hF;
        rd(4'h0);
        chk_w("ctrl_b", 0, rd_q);
        $display("test master reset and bus done");
        print_verdict;
    end
endmodule
